// *** rtl/ossw_osc_switch.sv ***
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps

// Notes on behaviour
// [RL1] x2 clock is half of x4 clock
// [RL2] internal 12.8/8/4 MHz, default 4 MHz
// [RL3] trim is eight bits, signed -128..+127
// [RL4] larger trim gives longer period
// [RL5] trim never loaded automatically from memory
// [RL6] software programs source, waits, then requests
// [RL7] external source enables input pin, crystal output
// [RL8] two external rising edges before switching
// [RL9] engaged flag set before internal stops
// [RL10] clearing source and request returns internal
// [RL11] external mode uses pin edges as x4
// [RL12] external mode forces pin clock out off
// [RL13] crystal mode output pin inverts input pin
// [RL14] RC mode pin outputs x4 when enabled
// [RL15] internal mode pin outputs x4 when enabled
// [RL16] internal mode releases input pin
// [RL17] no interrupts, no status break clearing
// [RL18] wait mode leaves oscillator running
// [RL19] stop with stop enable halts unless run in stop set
// [RL20] stop enable disables oscillator, overridable
// [RL21] source and crystal range encodings
// [RL22] internal frequency encodings, 00 default
// [RL23] reset clears request; ignored under bypass
// [RL24] clearing request before engage aborts switch
module ossw_osc_switch (
    input  wire logic                             clk_sys_i,
    input  wire logic                             reset_i,
    input  wire logic                             ce_i,
    input  wire logic [ossw_pkg::REG_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [ossw_pkg::REG_DATA_W-1:0]  reg_wdata_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    output logic      [ossw_pkg::REG_DATA_W-1:0]  reg_rdata_o,
    input  wire logic                             clock_input_pin_i,
    input  wire logic                             rc_clock_i,
    input  wire logic                             crystal_clock_i,
    input  wire logic                             stop_mode_i,
    input  wire logic                             stop_osc_enable_i,
    input  wire logic                             monitor_bypass_i,
    output logic                                  bus_clock_x4_o,
    output logic                                  bus_clock_x2_o,
    output logic                                  internal_osc_enable_o,
    output logic                                  external_clock_engaged_o,
    output logic                                  clock_input_pin_clock_o,
    output logic                                  crystal_amp_enable_o,
    output logic      [1:0]                       crystal_range_o,
    output logic      [7:0]                       internal_trim_value_o,
    output logic                                  clock_output_pin_o,
    output logic                                  clock_output_pin_oe_n_o,
    output logic                                  clock_output_pin_gpio_o
);
    import ossw_pkg::*;

    // software state
    logic [1:0]       clock_source_select;
    logic [1:0]       crystal_range_select;
    logic [1:0]       internal_freq_select;
    logic             external_clock_request;
    logic [7:0]       internal_trim_value;
    logic             second_pin_clock_out_enable;
    logic             run_in_stop_enable;

    // switch control
    ossw_state_e      state;
    ossw_state_e      next_state;
    logic [1:0]       edge_cnt;
    logic [1:0]       next_edge_cnt;
    logic             internal_on;

    // clock generation
    logic [NCO_W-1:0] nco_acc;
    logic             ext_prev;
    logic             x2_phase;
    logic             pin_out_level;

    // decode
    wire logic        wr_ctrl    = reg_wr_i && (reg_addr_i == REG_CTRL);
    wire logic        wr_trim    = reg_wr_i && (reg_addr_i == REG_TRIM);
    wire logic        wr_cfg     = reg_wr_i && (reg_addr_i == REG_CFG);
    wire logic [1:0]  wr_src     = reg_wdata_i[CTRL_SRC_LSB +: 2];
    wire logic [1:0]  wr_range   = reg_wdata_i[CTRL_RANGE_LSB +: 2];
    wire logic [1:0]  wr_freq    = reg_wdata_i[CTRL_FREQ_LSB +: 2];
    wire logic        wr_req     = reg_wdata_i[CTRL_REQ_BIT];

    // reserved codes are refused so the live selection stays legal
    wire logic [1:0]  next_range = (wr_ctrl && wr_range != RANGE_RESERVED) ? wr_range
                                                                           : crystal_range_select;
    wire logic [1:0]  next_freq  = (wr_ctrl && wr_freq != FREQ_RESERVED) ? wr_freq
                                                                         : internal_freq_select; // see [RL22]
    wire logic [1:0]  next_src   = wr_ctrl ? wr_src : clock_source_select; // see [RL21]
    // request cannot be raised while the monitor bypass input is high
    wire logic        next_req   = wr_ctrl ? (wr_req && !monitor_bypass_i)
                                           : (external_clock_request && !monitor_bypass_i); // see [RL23]
    // hardware keeps the pin clock out off while the external clock mode is chosen
    wire logic        next_pinout = (next_src == SRC_EXT_CLOCK) ? 1'b0
                                   : (wr_cfg ? reg_wdata_i[CFG_PINOUT_BIT]
                                             : second_pin_clock_out_enable); // see [RL12]

    // stop handling; wait mode has no input here, so it cannot disturb the clocks
    wire logic        osc_halted = stop_mode_i && stop_osc_enable_i && !run_in_stop_enable; // see [RL19] [RL20]
    wire logic        osc_run    = !osc_halted; // see [RL18]

    // external source choice for the activity check and the x4 tick
    wire logic        ext_src_level = (clock_source_select == SRC_EXT_CLOCK) ? clock_input_pin_i
                                    : (clock_source_select == SRC_EXT_RC)    ? rc_clock_i
                                                                             : crystal_clock_i;
    wire logic        ext_rise      = ext_src_level && !ext_prev && osc_run;
    wire logic        engaged       = (state == ST_ENGAGE) || (state == ST_EXT);

    // internal oscillator model: phase accumulator, trim scales the step
    wire logic [NCO_W-1:0] base_inc = (internal_freq_select == FREQ_8M0)  ? NCO_INC_8M0
                                    : (internal_freq_select == FREQ_12M8) ? NCO_INC_12M8
                                                                          : NCO_INC_4M0; // see [RL2]
    wire logic signed [NCO_W+8:0] trim_prod = $signed({1'b0, base_inc}) * $signed(internal_trim_value); // see [RL3]
    wire logic signed [NCO_W+8:0] trim_adj  = trim_prod >>> TRIM_SHIFT;
    // positive trim shrinks the step, so the period grows
    wire logic [NCO_W-1:0] nco_inc  = NCO_W'($signed({9'h000, base_inc}) - trim_adj); // see [RL4]
    wire logic [NCO_W:0]   nco_sum  = {1'b0, nco_acc} + {1'b0, nco_inc};
    wire logic             int_tick = internal_on && osc_run && nco_sum[NCO_W];

    // x4 comes from the internal model until the engaged flag is up
    wire logic        x4_tick   = engaged ? ext_rise : int_tick; // see [RL11] [RL24]
    wire logic        x2_tick   = x4_tick && x2_phase; // see [RL1]

    // pin functions
    wire logic        sel_ext     = clock_source_select != SRC_INTERNAL;
    wire logic        sel_crystal = clock_source_select == SRC_CRYSTAL;
    wire logic        pin_clk_out = second_pin_clock_out_enable
                                  && ((clock_source_select == SRC_INTERNAL)
                                      || (clock_source_select == SRC_EXT_RC)); // see [RL14] [RL15]

    // read data
    wire logic [7:0]  ctrl_rd = {engaged, external_clock_request, internal_freq_select,
                                 crystal_range_select, clock_source_select};
    wire logic [7:0]  cfg_rd  = {6'h00, run_in_stop_enable, second_pin_clock_out_enable};
    wire logic [7:0]  stat_rd = {5'h00, state == ST_CHECK, internal_on, engaged};
    wire logic [7:0]  rd_mux  = (reg_addr_i == REG_CTRL) ? ctrl_rd
                              : (reg_addr_i == REG_TRIM) ? internal_trim_value
                              : (reg_addr_i == REG_CFG)  ? cfg_rd
                                                         : stat_rd;

    // switch sequencing
    always_comb begin
        next_state    = state;
        next_edge_cnt = edge_cnt;
        unique case (state)
            ST_INT: begin
                next_edge_cnt = 2'h0;
                if (external_clock_request && sel_ext) begin
                    next_state = ST_CHECK; // see [RL6]
                end
            end
            ST_CHECK: begin
                if (!external_clock_request || !sel_ext) begin
                    next_state    = ST_INT; // see [RL24]
                    next_edge_cnt = 2'h0;
                end else if (ext_rise) begin
                    next_edge_cnt = edge_cnt + 2'h1;
                    if (edge_cnt + 2'h1 == EDGES_TO_SWITCH) begin
                        next_state = ST_ENGAGE; // see [RL8]
                    end
                end
            end
            ST_ENGAGE: begin
                // one cycle with both running gives a clean handover
                next_state = ST_EXT; // see [RL9]
            end
            ST_EXT: begin
                if (!sel_ext && !external_clock_request) begin
                    next_state = ST_INT; // see [RL10]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            clock_source_select         <= RST_SRC;
            crystal_range_select        <= RST_RANGE;
            internal_freq_select        <= RST_FREQ; // see [RL2]
            external_clock_request      <= 1'b0; // see [RL23]
            second_pin_clock_out_enable <= 1'b0;
            run_in_stop_enable          <= 1'b0;
        end else if (ce_i) begin
            clock_source_select         <= next_src;
            crystal_range_select        <= next_range;
            internal_freq_select        <= next_freq;
            external_clock_request      <= next_req;
            second_pin_clock_out_enable <= next_pinout;
            if (wr_cfg) begin
                run_in_stop_enable <= reg_wdata_i[CFG_RUNSTOP_BIT];
            end
        end
    end

    // only software writes trim; nothing copies a factory value in
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            internal_trim_value <= RST_TRIM; // see [RL5]
        end else if (ce_i && wr_trim) begin
            internal_trim_value <= reg_wdata_i; // see [RL3]
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state       <= ST_INT;
            edge_cnt    <= 2'h0;
            internal_on <= 1'b1;
        end else if (ce_i) begin
            state       <= next_state;
            edge_cnt    <= next_edge_cnt;
            // internal stops only after engaged was already shown
            internal_on <= (next_state != ST_EXT); // see [RL9] [RL10]
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            nco_acc  <= '0;
            ext_prev <= 1'b0;
            x2_phase <= 1'b0;
        end else if (ce_i) begin
            if (internal_on && osc_run) begin
                nco_acc <= nco_sum[NCO_W-1:0];
            end
            ext_prev <= ext_src_level;
            if (x4_tick) begin
                x2_phase <= !x2_phase; // see [RL1]
            end
        end
    end

    // clock outputs are one-cycle ticks; the pin shows a square wave at half the tick rate
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            bus_clock_x4_o <= 1'b0;
            bus_clock_x2_o <= 1'b0;
            pin_out_level  <= 1'b0;
        end else if (ce_i) begin
            bus_clock_x4_o <= x4_tick;
            bus_clock_x2_o <= x2_tick; // see [RL1]
            if (x4_tick) begin
                pin_out_level <= !pin_out_level;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            clock_output_pin_o      <= 1'b0;
            clock_output_pin_oe_n_o <= 1'b1;
            clock_output_pin_gpio_o <= 1'b1;
        end else if (ce_i) begin
            if (sel_crystal) begin
                clock_output_pin_o      <= !clock_input_pin_i; // see [RL13]
                clock_output_pin_oe_n_o <= 1'b0;
                clock_output_pin_gpio_o <= 1'b0;
            end else if (pin_clk_out) begin
                clock_output_pin_o      <= pin_out_level; // see [RL14] [RL15]
                clock_output_pin_oe_n_o <= 1'b0;
                clock_output_pin_gpio_o <= 1'b0;
            end else begin
                clock_output_pin_o      <= 1'b0; // see [RL12]
                clock_output_pin_oe_n_o <= 1'b1;
                clock_output_pin_gpio_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            internal_osc_enable_o    <= 1'b1;
            external_clock_engaged_o <= 1'b0;
            clock_input_pin_clock_o  <= 1'b0;
            crystal_amp_enable_o     <= 1'b0;
            crystal_range_o          <= RST_RANGE;
            internal_trim_value_o    <= RST_TRIM;
        end else if (ce_i) begin
            internal_osc_enable_o    <= internal_on && osc_run; // see [RL19] [RL20]
            external_clock_engaged_o <= engaged; // see [RL9]
            clock_input_pin_clock_o  <= sel_ext; // see [RL7] [RL16]
            crystal_amp_enable_o     <= sel_crystal && osc_run; // see [RL7]
            crystal_range_o          <= crystal_range_select; // see [RL21]
            internal_trim_value_o    <= internal_trim_value;
        end
    end

    // plain read port, no side effects on read and no flags to clear
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00; // see [RL17]
        end
    end

endmodule // ossw_osc_switch

// *** rtl/ossw_pkg.sv ***
package ossw_pkg;

    // register map, plain byte-wide port
    localparam int               REG_ADDR_W      = 2;
    localparam int               REG_DATA_W      = 8;
    localparam logic [1:0]       REG_CTRL        = 2'h0;
    localparam logic [1:0]       REG_TRIM        = 2'h1;
    localparam logic [1:0]       REG_CFG         = 2'h2;
    localparam logic [1:0]       REG_STATUS      = 2'h3;

    // control register fields
    localparam int               CTRL_SRC_LSB    = 0;
    localparam int               CTRL_RANGE_LSB  = 2;
    localparam int               CTRL_FREQ_LSB   = 4;
    localparam int               CTRL_REQ_BIT    = 6;
    localparam int               CTRL_ENG_BIT    = 7;
    // configuration register fields
    localparam int               CFG_PINOUT_BIT  = 0;
    localparam int               CFG_RUNSTOP_BIT = 1;
    // status register fields
    localparam int               STAT_ENG_BIT    = 0;
    localparam int               STAT_INTON_BIT  = 1;
    localparam int               STAT_CHECK_BIT  = 2;

    // clock source encodings
    localparam logic [1:0]       SRC_INTERNAL    = 2'h0;
    localparam logic [1:0]       SRC_EXT_CLOCK   = 2'h1;
    localparam logic [1:0]       SRC_EXT_RC      = 2'h2;
    localparam logic [1:0]       SRC_CRYSTAL     = 2'h3;
    // crystal range encodings
    localparam logic [1:0]       RANGE_8_32M     = 2'h0;
    localparam logic [1:0]       RANGE_1_8M      = 2'h1;
    localparam logic [1:0]       RANGE_32_100K   = 2'h2;
    localparam logic [1:0]       RANGE_RESERVED  = 2'h3;
    // internal frequency encodings
    localparam logic [1:0]       FREQ_4M0        = 2'h0;
    localparam logic [1:0]       FREQ_8M0        = 2'h1;
    localparam logic [1:0]       FREQ_12M8       = 2'h2;
    localparam logic [1:0]       FREQ_RESERVED   = 2'h3;

    // reset values
    localparam logic [1:0]       RST_SRC         = SRC_INTERNAL;
    localparam logic [1:0]       RST_RANGE       = RANGE_8_32M;
    localparam logic [1:0]       RST_FREQ        = FREQ_4M0;
    localparam logic [7:0]       RST_TRIM        = 8'h00;

    // timing: system clock and internal oscillator model
    localparam longint           CLK_SYS_HZ      = 25_000_000;
    localparam longint           INT_4M0_HZ      = 4_000_000;
    localparam longint           INT_8M0_HZ      = 8_000_000;
    localparam longint           INT_12M8_HZ     = 12_800_000;
    localparam int               NCO_W           = 24;
    localparam logic [NCO_W-1:0] NCO_INC_4M0     = NCO_W'((INT_4M0_HZ << NCO_W) / CLK_SYS_HZ);
    localparam logic [NCO_W-1:0] NCO_INC_8M0     = NCO_W'((INT_8M0_HZ << NCO_W) / CLK_SYS_HZ);
    localparam logic [NCO_W-1:0] NCO_INC_12M8    = NCO_W'((INT_12M8_HZ << NCO_W) / CLK_SYS_HZ);
    // one trim step moves the period by about 1/512
    localparam int               TRIM_SHIFT      = 9;
    localparam logic [1:0]       EDGES_TO_SWITCH = 2'h2;

    typedef enum logic [1:0] {
        ST_INT    = 2'b00,
        ST_CHECK  = 2'b01,
        ST_ENGAGE = 2'b10,
        ST_EXT    = 2'b11
    } ossw_state_e;

endpackage

// *** sim/ossw_ext_src_model.sv ***
`timescale 1ns/100ps

// stand-in for crystal, RC network or external clock source
module ossw_ext_src_model (
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [3:0] half_i,
    output logic            pin_o,
    output logic            rc_o,
    output logic            xtal_o
);
    logic [3:0] cnt;

    // a dead source sits low: no edges for the switch logic to count
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt   <= 4'h0;
            pin_o <= 1'b0;
        end else if (cnt >= half_i - 4'h1) begin
            cnt   <= 4'h0;
            pin_o <= ~pin_o;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    assign rc_o   = pin_o;
    assign xtal_o = pin_o;
endmodule // ossw_ext_src_model

// *** sim/ossw_properties.sv ***
`timescale 1ns/100ps

module ossw_properties (
    input wire logic                             clk_sys_i,
    input wire logic                             reset_i,
    input wire logic                             ce_i,
    input wire logic [ossw_pkg::REG_ADDR_W-1:0]  reg_addr_i,
    input wire logic [ossw_pkg::REG_DATA_W-1:0]  reg_wdata_i,
    input wire logic                             reg_wr_i,
    input wire logic                             clock_input_pin_i,
    input wire logic                             stop_mode_i,
    input wire logic                             stop_osc_enable_i,
    input wire logic                             bus_clock_x4_o,
    input wire logic                             bus_clock_x2_o,
    input wire logic                             internal_osc_enable_o,
    input wire logic                             external_clock_engaged_o,
    input wire logic                             crystal_amp_enable_o,
    input wire logic [7:0]                       internal_trim_value_o,
    input wire logic                             clock_output_pin_o,
    input wire logic                             clock_output_pin_oe_n_o,
    input wire logic                             clock_output_pin_gpio_o
);
    import ossw_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    logic x2_last;
    logic run_stop;
    wire  trim_wr = ce_i && reg_wr_i && reg_addr_i == REG_TRIM;
    wire  ctrl_clr = ce_i && reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i == 8'h00;

    // run-in-stop is on no port
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            x2_last  <= 1'b0;
            run_stop <= 1'b0;
        end else begin
            if (bus_clock_x4_o) begin
                x2_last <= bus_clock_x2_o;
            end
            if (ce_i && reg_wr_i && reg_addr_i == REG_CFG) begin
                run_stop <= reg_wdata_i[CFG_RUNSTOP_BIT];
            end
        end
    end

    reset_vals_a: assert property ($fell(reset_i) |-> internal_osc_enable_o &&
        !external_clock_engaged_o && clock_output_pin_oe_n_o && internal_trim_value_o == 8'h00)
        else $error("outputs not at reset values");
    x2_on_x4_a: assert property (bus_clock_x2_o |-> bus_clock_x4_o)
        else $error("x2 tick without x4 tick");
    x2_alternate_a: assert property (bus_clock_x4_o && x2_last |-> !bus_clock_x2_o)
        else $error("x2 tick on consecutive x4 ticks");
    engage_first_a: assert property ($fell(internal_osc_enable_o) && !stop_mode_i &&
        !$past(stop_mode_i) |-> $past(external_clock_engaged_o)) else $error("internal stopped before engage");
    engage_overlap_a: assert property ($rose(external_clock_engaged_o) |-> internal_osc_enable_o)
        else $error("internal off at engage");
    trim_copy_a: assert property ($past(trim_wr, 2) && !$past(trim_wr)
        |-> internal_trim_value_o == $past(reg_wdata_i, 2)) else $error("trim copy wrong");
    xtal_invert_a: assert property (crystal_amp_enable_o && $past(crystal_amp_enable_o) |->
        !clock_output_pin_oe_n_o && clock_output_pin_o == !$past(clock_input_pin_i))
        else $error("crystal output not inverted input");
    pin_owner_a: assert property (clock_output_pin_oe_n_o == clock_output_pin_gpio_o)
        else $error("pin driven and free together");
    stop_halt_a: assert property ((stop_mode_i && stop_osc_enable_i && !run_stop)[*3]
        |-> !bus_clock_x4_o) else $error("tick while halted in stop");
    back_internal_a: assert property (ctrl_clr && external_clock_engaged_o
        |-> ##[1:4] !external_clock_engaged_o) else $error("external not disengaged");

    engaged_c: cover property ($rose(external_clock_engaged_o));
    crystal_c: cover property ($rose(crystal_amp_enable_o));
    halted_c: cover property ((stop_mode_i && stop_osc_enable_i)[*4]);
endmodule // ossw_properties

bind ossw_osc_switch ossw_properties u_props (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .clock_input_pin_i(clock_input_pin_i),
    .stop_mode_i(stop_mode_i), .stop_osc_enable_i(stop_osc_enable_i), .bus_clock_x4_o(bus_clock_x4_o),
    .bus_clock_x2_o(bus_clock_x2_o), .internal_osc_enable_o(internal_osc_enable_o),
    .external_clock_engaged_o(external_clock_engaged_o), .crystal_amp_enable_o(crystal_amp_enable_o),
    .internal_trim_value_o(internal_trim_value_o), .clock_output_pin_o(clock_output_pin_o),
    .clock_output_pin_oe_n_o(clock_output_pin_oe_n_o), .clock_output_pin_gpio_o(clock_output_pin_gpio_o)
);

// *** sim/oscillator_source_switch_control_tb.sv ***
`timescale 1ns/100ps

module oscillator_source_switch_control_tb;
    import ossw_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic [1:0] addr      = 2'h0;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic       stop      = 1'b0;
    logic       stop_en   = 1'b0;
    logic       bypass    = 1'b0;
    logic       src_run   = 1'b0;
    logic [7:0] rdata, trim;
    logic [1:0] range;
    logic       pin, rc_clk, xt_clk, x4, x2, int_en, eng, pin_clk, amp, pin_o, oe_n, gpio;
    int         miscompares = 0;
    int         cmp_count   = 0;
    int         n4 = 0, n2 = 0;
    int         c4, c2, c0;
    int         rate [3] = '{160, 320, 512};

    ossw_ext_src_model src (.clk_i(clk_sys_i), .run_i(src_run), .half_i(4'h4), .pin_o(pin), .rc_o(rc_clk),
        .xtal_o(xt_clk));
    ossw_osc_switch dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .clock_input_pin_i(pin),
        .rc_clock_i(rc_clk), .crystal_clock_i(xt_clk), .stop_mode_i(stop), .stop_osc_enable_i(stop_en),
        .monitor_bypass_i(bypass), .bus_clock_x4_o(x4), .bus_clock_x2_o(x2), .internal_osc_enable_o(int_en),
        .external_clock_engaged_o(eng), .clock_input_pin_clock_o(pin_clk), .crystal_amp_enable_o(amp),
        .crystal_range_o(range), .internal_trim_value_o(trim), .clock_output_pin_o(pin_o),
        .clock_output_pin_oe_n_o(oe_n), .clock_output_pin_gpio_o(gpio));

    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        n4 <= n4 + int'(x4);
        n2 <= n2 + int'(x2);
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // counts drift a tick or two with nco phase
    task automatic near(input int got, input int exp);
        chk(16'((got >= exp - 2 && got <= exp + 2) ? exp : got), 16'(exp));
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic measure(input int n);
        int a4, a2;
        a4 = n4;
        a2 = n2;
        repeat (n) @(posedge clk_sys_i);
        c4 = n4 - a4;
        c2 = n2 - a2;
    endtask
    task automatic wait_eng(input logic want);
        for (int i = 0; i < 300 && eng !== want; i++) @(posedge clk_sys_i);
        #1;
        if (eng !== want) begin
            miscompares++;
            end_of_test();
        end
    endtask

    initial begin
        #4000000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rreg(REG_CTRL, 8'h00);
        rreg(REG_TRIM, 8'h00);
        rreg(REG_STATUS, 8'h02);
        for (int f = 0; f < 3; f++) begin
            wreg(REG_CTRL, 8'(f << CTRL_FREQ_LSB));
            idle(4);
            measure(1000);
            near(c4, rate[f]);
            near(c2, rate[f] / 2);
        end
        wreg(REG_CTRL, 8'h30);
        rreg(REG_CTRL, 8'h20);
        wreg(REG_CTRL, 8'h00);
        wreg(REG_TRIM, 8'h7F);
        idle(4);
        chk(16'(trim), 16'h007F);
        measure(1000);
        near(c4, 120);
        wreg(REG_TRIM, 8'h80);
        idle(4);
        measure(1000);
        near(c4, 200);
        wreg(REG_TRIM, 8'h00);
        stop <= 1'b1;
        measure(200);
        near(c4, 32);
        stop_en <= 1'b1;
        idle(3);
        measure(200);
        chk(16'(c4), 16'h0000);
        wreg(REG_CFG, 8'h02);
        idle(3);
        measure(200);
        near(c4, 32);
        stop    <= 1'b0;
        stop_en <= 1'b0;
        wreg(REG_CFG, 8'h01);
        idle(4);
        chk(16'({oe_n, gpio, pin_clk}), 16'h0000);
        wreg(REG_CTRL, 8'h02);
        idle(4);
        chk(16'({oe_n, pin_clk}), 16'h0001);
        wreg(REG_CTRL, 8'h01);
        idle(4);
        rreg(REG_CFG, 8'h00);
        chk(16'({oe_n, gpio, pin_clk}), 16'h0007);
        // silent source: sits checking, then aborts
        wreg(REG_CTRL, 8'h41);
        idle(40);
        rreg(REG_STATUS, 8'h06);
        wreg(REG_CTRL, 8'h01);
        idle(4);
        rreg(REG_STATUS, 8'h02);
        bypass <= 1'b1;
        wreg(REG_CTRL, 8'h41);
        rreg(REG_CTRL, 8'h01);
        bypass <= 1'b0;
        src_run <= 1'b1;
        idle(40);
        wreg(REG_CTRL, 8'h41);
        wait_eng(1'b1);
        idle(4);
        chk(16'(int_en), 16'h0000);
        rreg(REG_CTRL, 8'hC1);
        measure(800);
        near(c4, 100);
        near(c2, 50);
        wreg(REG_CTRL, 8'h00);
        wait_eng(1'b0);
        idle(4);
        chk(16'(int_en), 16'h0001);
        wreg(REG_CTRL, 8'h07);
        idle(40);
        src_run <= 1'b0;
        idle(4);
        chk(16'({amp, range, oe_n, pin_o}), 16'h0015);
        wreg(REG_CTRL, 8'h0F);
        rreg(REG_CTRL, 8'h07);
        wreg(REG_CTRL, 8'h00);
        idle(4);
        chk(16'({amp, pin_clk}), 16'h0000);
        end_of_test();
    end
endmodule // oscillator_source_switch_control_tb
